/* core/rtc_alarm_timer_temp_regs.sv */
// RTC month/year alarm, countdown value, temperature and non-volatile register bank.
// Assumes a synchronous byte register port; a sensor supplies temperature codes.
// Assumes BCD time inputs from the calendar counters; the alarm date flag is a level.
//
// Behaviour
// - Month alarm bit 7 enables month comparison; clear means ignore month.
// - Month alarm bits 4..0 hold BCD month; bits 6..5 unused, read zero.
// - Year alarm bit 7 enables year match; bits 6..0 BCD year.
// - Sixteen-bit countdown value split low byte 18h, high byte 19h.
// - High byte takes any value and forms upper eight timer bits.
// - Temperature code is degrees plus sixty, one degree per step.
// - Host accesses see a frozen cached temperature copy.
// - With thermometer disabled, host may write temperature register directly.
// - Two user non-volatile bytes at 28h and 29h, any value.
// - Control page holds one control and three calibration bytes.
// - Control fields: trickle bits 7..4, clock out 3..2, thermometer 1..0.
// - Calibration bytes hold offset, coefficient, turnover for compensation.
// - Thermometer enable starts periodic scans; scan bit clear means every second.
`timescale 1ns/1ps
`include "rtc_regs_defs.svh"

module rtc_alarm_timer_temp_regs
    import rtc_regs_pkg::*;
#(
    parameter int SCAN_1S_CYCLES  = `SCAN_1S_CYCLES,
    parameter int SCAN_16S_CYCLES = `SCAN_1S_CYCLES * `SCAN_16S_S
) (
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    input  wire logic       reg_access,
    input  wire logic       reg_write,
    input  wire logic [5:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic [7:0] sensor_code,
    input  wire logic       sensor_valid,
    output logic            sensor_start,
    input  wire logic [7:0] time_month,
    input  wire logic [7:0] time_year,
    output logic            alarm_date_match,
    output logic     [15:0] countdown_value,
    output logic      [7:0] temperature_code,
    output nv_control_t     nv_control,
    output xtal_cal_t       xtal_cal
);

    // ======================================================================
    // Reset release
    logic rst_meta_q;
    logic rst_sync_q;

    // Entry is asynchronous, release waits two edges
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // ======================================================================
    // Register storage
    alarm_field_t month_q,   month_d;
    alarm_field_t year_q,    year_d;
    logic [7:0]   cnt_lo_q,  cnt_lo_d;
    logic [7:0]   cnt_hi_q,  cnt_hi_d;
    nv_control_t  ctrl_q,    ctrl_d;
    xtal_cal_t    cal_q,     cal_d;
    logic [7:0]   rdata_q,   rdata_d;

    logic wr;
    assign wr = reg_access && reg_write;

    always_comb begin
        month_d  = month_q;
        year_d   = year_q;
        cnt_lo_d = cnt_lo_q;
        cnt_hi_d = cnt_hi_q;
        ctrl_d   = ctrl_q;
        cal_d    = cal_q;
        if (wr) begin
            if (reg_addr == `ADDR_ALARM_MONTH) begin
                month_d = alarm_field_t'(reg_wdata & `MONTH_FIELD_MASK);
            end else if (reg_addr == `ADDR_ALARM_YEAR) begin
                year_d = alarm_field_t'(reg_wdata);
            end else if (reg_addr == `ADDR_COUNT_LOW) begin
                cnt_lo_d = reg_wdata;
            end else if (reg_addr == `ADDR_COUNT_HIGH) begin
                cnt_hi_d = reg_wdata;
            end else if (reg_addr == `ADDR_NV_CONTROL) begin
                ctrl_d = nv_control_t'(reg_wdata);
            end else if (reg_addr == `ADDR_CRYSTAL_OFFSET_TRIM) begin
                cal_d.crystal_offset_trim = reg_wdata;
            end else if (reg_addr == `ADDR_CRYSTAL_QUADRATIC_COEFFICIENT) begin
                cal_d.crystal_quadratic_coefficient = reg_wdata;
            end else if (reg_addr == `ADDR_XTAL_TURNOVER) begin
                cal_d.crystal_turnover_temperature = reg_wdata & `TURNOVER_MASK;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            month_q  <= alarm_field_t'(`RESET_BYTE);
            year_q   <= alarm_field_t'(`RESET_BYTE);
            cnt_lo_q <= `RESET_BYTE;
            cnt_hi_q <= `RESET_BYTE;
            ctrl_q   <= nv_control_t'(`RESET_CTRL);
            cal_q    <= xtal_cal_t'({`RESET_BYTE, `RESET_BYTE, `RESET_BYTE});
        end else begin
            month_q  <= month_d;
            year_q   <= year_d;
            cnt_lo_q <= cnt_lo_d;
            cnt_hi_q <= cnt_hi_d;
            ctrl_q   <= ctrl_d;
            cal_q    <= cal_d;
        end
    end

    // ======================================================================
    // User bytes, one flip-flop byte per entry
    for (genvar i = 0; i < 2; i++) begin : g_user
        logic [7:0] byte_q;
        logic [7:0] byte_d;
        logic       hit;

        // Entry i sits at the first user address plus i
        assign hit = wr && (reg_addr == 6'(`ADDR_USER_NV0 + i));

        always_comb begin
            byte_d = byte_q;
            if (hit) begin
                byte_d = reg_wdata;
            end
        end

        always_ff @(posedge clk_sys or negedge rst_sync_q) begin
            if (!rst_sync_q) begin
                byte_q <= `RESET_BYTE;
            end else begin
                byte_q <= byte_d;
            end
        end
    end

    // ======================================================================
    // Temperature measurement and host cache
    temp_state_t ts_q,      ts_d;
    logic [31:0] scan_q,    scan_d;
    logic [7:0]  temp_q,    temp_d;
    logic [7:0]  pend_q,    pend_d;
    logic        pend_v_q,  pend_v_d;
    logic        start_q,   start_d;
    logic [31:0] scan_limit;

    // Bit 0 clear gives one scan a second, set gives the long period
    assign scan_limit = ctrl_q.thermo_scan_period_select ? SCAN_16S_CYCLES - 1 : SCAN_1S_CYCLES - 1;

    always_comb begin
        ts_d     = ts_q;
        scan_d   = scan_q;
        temp_d   = temp_q;
        pend_d   = pend_q;
        pend_v_d = pend_v_q;
        start_d  = 1'b0;
        // Pending code reaches the cache only outside host access; a direct host write below still wins
        if (pend_v_q && !reg_access) begin
            temp_d   = pend_q;
            pend_v_d = 1'b0;
        end
        case (ts_q)
            TS_IDLE: begin
                if (ctrl_q.thermo_enable) begin
                    if (scan_q >= scan_limit) begin
                        scan_d  = 32'h0000_0000;
                        start_d = 1'b1;
                        ts_d    = TS_MEASURE;
                    end else begin
                        scan_d = scan_q + 32'h0000_0001;
                    end
                end else begin
                    scan_d = 32'h0000_0000;
                end
            end
            TS_MEASURE: begin
                // Disabling the thermometer abandons the request
                if (!ctrl_q.thermo_enable) begin
                    ts_d = TS_IDLE;
                end else if (sensor_valid) begin
                    pend_d   = sensor_code;
                    pend_v_d = 1'b1;
                    ts_d     = TS_HOLD;
                end
            end
            TS_HOLD: begin
                ts_d = TS_IDLE;
            end
            default: begin
                ts_d = TS_IDLE;
            end
        endcase
        if (wr && reg_addr == `ADDR_TEMPERATURE && !ctrl_q.thermo_enable) begin
            temp_d   = reg_wdata;
            pend_v_d = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            ts_q     <= TS_IDLE;
            scan_q   <= 32'h0000_0000;
            temp_q   <= `RESET_TEMP;
            pend_q   <= `RESET_BYTE;
            pend_v_q <= 1'b0;
            start_q  <= 1'b0;
        end else begin
            ts_q     <= ts_d;
            scan_q   <= scan_d;
            temp_q   <= temp_d;
            pend_q   <= pend_d;
            pend_v_q <= pend_v_d;
            start_q  <= start_d;
        end
    end

    // ======================================================================
    // Read data

    always_comb begin
        rdata_d = rdata_q;
        if (reg_access && !reg_write) begin
            if (reg_addr == `ADDR_ALARM_MONTH) begin
                rdata_d = month_q;
            end else if (reg_addr == `ADDR_ALARM_YEAR) begin
                rdata_d = year_q;
            end else if (reg_addr == `ADDR_COUNT_LOW) begin
                rdata_d = cnt_lo_q;
            end else if (reg_addr == `ADDR_COUNT_HIGH) begin
                rdata_d = cnt_hi_q;
            end else if (reg_addr == `ADDR_TEMPERATURE) begin
                rdata_d = temp_q;
            end else if (reg_addr == `ADDR_USER_NV0) begin
                rdata_d = g_user[0].byte_q;
            end else if (reg_addr == `ADDR_USER_NV1) begin
                rdata_d = g_user[1].byte_q;
            end else if (reg_addr == `ADDR_NV_CONTROL) begin
                rdata_d = ctrl_q;
            end else if (reg_addr == `ADDR_CRYSTAL_OFFSET_TRIM) begin
                rdata_d = cal_q.crystal_offset_trim;
            end else if (reg_addr == `ADDR_CRYSTAL_QUADRATIC_COEFFICIENT) begin
                rdata_d = cal_q.crystal_quadratic_coefficient;
            end else if (reg_addr == `ADDR_XTAL_TURNOVER) begin
                rdata_d = cal_q.crystal_turnover_temperature;
            end else begin
                rdata_d = `RESET_BYTE;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            rdata_q <= `RESET_BYTE;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // ======================================================================
    // Alarm date compare
    logic match_q;
    logic match_d;

    always_comb begin
        // Disabled fields always match
        match_d = (!month_q.en || ({3'b000, month_q.value[4:0]} == time_month)) &&
                  (!year_q.en  || ({1'b0, year_q.value} == time_year));
    end

    always_ff @(posedge clk_sys or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            match_q <= 1'b0;
        end else begin
            match_q <= match_d;
        end
    end

    assign reg_rdata        = rdata_q;
    assign alarm_date_match = match_q;
    assign sensor_start     = start_q;
    assign countdown_value  = {cnt_hi_q, cnt_lo_q};
    assign temperature_code = temp_q;
    assign nv_control       = ctrl_q;
    assign xtal_cal         = cal_q;

endmodule

/* core/rtc_regs_defs.svh */
// Offsets, field positions, reset values and timing counts for the RTC register bank.
// Assumes a byte-wide register port addressed by 6-bit register addresses.
`ifndef RTC_REGS_DEFS_SVH
`define RTC_REGS_DEFS_SVH

// ==========================================================================
// Register addresses
`define ADDR_ALARM_MONTH    6'h15
`define ADDR_ALARM_YEAR     6'h16
`define ADDR_COUNT_LOW      6'h18
`define ADDR_COUNT_HIGH     6'h19
`define ADDR_TEMPERATURE    6'h20
`define ADDR_USER_NV0       6'h28
`define ADDR_USER_NV1       6'h29
`define ADDR_NV_CONTROL     6'h30
`define ADDR_CRYSTAL_OFFSET_TRIM    6'h31
`define ADDR_CRYSTAL_QUADRATIC_COEFFICIENT      6'h32
`define ADDR_XTAL_TURNOVER  6'h33

// ==========================================================================
// Field positions
`define ALARM_EN_BIT        7
`define MONTH_FIELD_MASK    8'h9F
`define TURNOVER_MASK       8'h3F
`define CTRL_THERMO_EN_BIT  1
`define CTRL_SCAN_BIT       0

// ==========================================================================
// Reset values
`define RESET_BYTE          8'h00
`define RESET_TEMP          8'h3C
`define RESET_CTRL          8'h02

// ==========================================================================
// Timing
`define CLK_FREQ_HZ         100000000
`define SCAN_1S_S           1
`define SCAN_16S_S          16
`define SCAN_1S_CYCLES      (`CLK_FREQ_HZ * `SCAN_1S_S)

`endif

/* core/rtc_regs_pkg.sv */
// Types shared by the RTC register bank.
// Assumes the defines header is included by the modules that need numbers.
package rtc_regs_pkg;

    typedef struct packed {
        logic [3:0] trickle_select;
        logic [1:0] divided_clock_output_select;
        logic       thermo_enable;
        logic       thermo_scan_period_select;
    } nv_control_t;

    typedef struct packed {
        logic       en;
        logic [6:0] value;
    } alarm_field_t;

    typedef struct packed {
        logic [7:0] crystal_offset_trim;
        logic [7:0] crystal_quadratic_coefficient;
        logic [7:0] crystal_turnover_temperature;
    } xtal_cal_t;

    typedef enum logic [1:0] {
        TS_IDLE    = 2'b00,
        TS_MEASURE = 2'b01,
        TS_HOLD    = 2'b10
    } temp_state_t;

endpackage

/* verification/rtc_regs_props.sv */
// Port-level checks for the RTC register bank.
// Assumes one clock domain; bound into every bank instance.
`timescale 1ns/1ps
module rtc_regs_props
    import rtc_regs_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        rst_b,
    input wire logic        reg_access,
    input wire logic        reg_write,
    input wire logic [5:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic [7:0]  reg_rdata,
    input wire logic        sensor_start,
    input wire logic [7:0]  time_month,
    input wire logic [7:0]  time_year,
    input wire logic        alarm_date_match,
    input wire logic [15:0] countdown_value,
    input wire logic [7:0]  temperature_code,
    input wire nv_control_t nv_control
);
    // ==========================================================
    // Shadow alarm bytes and settle count
    logic [7:0] mon_q, mon_d, yr_q, yr_d;
    logic [1:0] live_q, live_d;
    logic       exp_match;
    always_comb begin
        mon_d  = mon_q;
        yr_d   = yr_q;
        live_d = (live_q == 2'h3) ? live_q : live_q + 2'h1;
        if (reg_access && reg_write && reg_addr == 6'h15) begin
            mon_d = reg_wdata & 8'h9F;
        end
        if (reg_access && reg_write && reg_addr == 6'h16) begin
            yr_d = reg_wdata;
        end
    end
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            mon_q  <= 8'h00;
            yr_q   <= 8'h00;
            live_q <= 2'h0;
        end else begin
            mon_q  <= mon_d;
            yr_q   <= yr_d;
            live_q <= live_d;
        end
    end
    assign exp_match = (!mon_q[7] || {3'h0, mon_q[4:0]} == time_month) && (!yr_q[7] || {1'h0, yr_q[6:0]} == time_year);
    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    sequence wr_at(logic [5:0] a);
        reg_access && reg_write && reg_addr == a;
    endsequence
    sequence rd_at(logic [5:0] a);
        reg_access && !reg_write && reg_addr == a;
    endsequence
    count_low_a: assert property (wr_at(6'h18) |=> countdown_value[7:0] == $past(reg_wdata))
        else $error("countdown low byte not loaded");
    count_high_a: assert property (wr_at(6'h19) |=> countdown_value[15:8] == $past(reg_wdata))
        else $error("countdown high byte not loaded");
    month_unused_a: assert property (rd_at(6'h15) |=> reg_rdata[6:5] == 2'b00)
        else $error("month alarm unused bits not zero");
    temp_frozen_a: assert property (reg_access && !(reg_write && reg_addr == 6'h20) |=> $stable(temperature_code))
        else $error("temperature changed during access");
    temp_write_a: assert property (wr_at(6'h20) ##0 !nv_control.thermo_enable |=> temperature_code == $past(reg_wdata))
        else $error("direct temperature write lost");
    scan_gap_a: assert property (sensor_start |=> !sensor_start [*8])
        else $error("measurement requests too close");
    match_eq_a: assert property (live_q == 2'h3 |-> alarm_date_match == $past(exp_match))
        else $error("alarm date match wrong");
    unmapped_a: assert property (rd_at(6'h34) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule

bind rtc_alarm_timer_temp_regs rtc_regs_props rtc_regs_props_inst (.clk_sys, .rst_b, .reg_access, .reg_write,
    .reg_addr, .reg_wdata, .reg_rdata, .sensor_start, .time_month, .time_year, .alarm_date_match, .countdown_value,
    .temperature_code, .nv_control);

/* verification/rtc_sensor_model.sv */
// Behavioural temperature sensor on the far side of the bank.
// Assumes start pulses on the shared clock.
`timescale 1ns/1ps
module rtc_sensor_model #(
    parameter logic [7:0] CODE = 8'hFA
) (
    input  wire logic       clk_sys,
    input  wire logic       sensor_start,
    output logic            sensor_valid,
    output logic      [7:0] sensor_code
);
    initial sensor_valid = 1'b0;
    // Answer three cycles after a request
    always @(posedge clk_sys) begin
        if (sensor_start) begin
            repeat (3) @(posedge clk_sys);
            #1 sensor_valid = 1'b1;
            @(posedge clk_sys);
            #1 sensor_valid = 1'b0;
        end
    end
    // Code line carries junk outside the valid pulse
    assign sensor_code = sensor_valid ? CODE : ~CODE;
endmodule

/* verification/testbench.sv */
// Self-checking bench for the RTC register bank.
// Assumes the sensor model and shortened scan counts.
`timescale 1ns/1ps
module testbench;
    import rtc_regs_pkg::*;
    logic        clk_sys    = 1'b0;
    logic        rst_b      = 1'b0;
    logic        reg_access = 1'b0;
    logic        reg_write  = 1'b0;
    logic [5:0]  reg_addr   = 6'h00;
    logic [7:0]  reg_wdata  = 8'h00;
    logic [7:0]  time_month = 8'h12;
    logic [7:0]  time_year  = 8'h79;
    logic [7:0]  reg_rdata, sensor_code, temperature_code;
    logic        sensor_valid, sensor_start, alarm_date_match;
    logic [15:0] countdown_value;
    nv_control_t nv_control;
    xtal_cal_t   xtal_cal;
    int          n_mismatch = 0;
    int          checks     = 0;
    always #5 clk_sys = ~clk_sys;
    rtc_alarm_timer_temp_regs #(.SCAN_1S_CYCLES(20), .SCAN_16S_CYCLES(40)) rtc_alarm_timer_temp_regs_inst (
        .clk_sys, .rst_b, .reg_access, .reg_write, .reg_addr, .reg_wdata, .reg_rdata, .sensor_code,
        .sensor_valid, .sensor_start, .time_month, .time_year, .alarm_date_match, .countdown_value,
        .temperature_code, .nv_control, .xtal_cal);
    rtc_sensor_model rtc_sensor_model_inst (.clk_sys, .sensor_start, .sensor_valid, .sensor_code);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #1;
        reg_access = 1'b1;
        reg_write = w;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clk_sys);
        #1;
        reg_access = 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        acc(1'b0, a, 8'h00);
        chk({8'h00, reg_rdata}, {8'h00, e});
    endtask
    task automatic wait_chk_match(input logic e);
        repeat (2) @(posedge clk_sys);
        #1;
        chk({15'h0000, alarm_date_match}, {15'h0000, e});
    endtask
    task automatic t_reset();
        chk({8'h00, temperature_code}, 16'h003C);
        chk({8'h00, nv_control}, 16'h0002);
        chk(countdown_value, 16'h0000);
        chk(xtal_cal[23:8], 16'h0000);
        chk({8'h00, xtal_cal[7:0]}, 16'h0000);
        rd(6'h31, 8'h00);
        rd(6'h34, 8'h00);
        $display("reset test done");
    endtask
    task automatic t_alarm();
        acc(1'b1, 6'h15, 8'h92);
        acc(1'b1, 6'h16, 8'hF9);
        rd(6'h15, 8'h92);
        chk({15'h0000, alarm_date_match}, 16'h0001);
        time_month = 8'h11;
        wait_chk_match(1'b0);
        acc(1'b1, 6'h15, 8'h71);
        rd(6'h15, 8'h11);
        chk({15'h0000, alarm_date_match}, 16'h0001);
        time_year = 8'h00;
        wait_chk_match(1'b0);
        acc(1'b1, 6'h16, 8'h79);
        wait_chk_match(1'b1);
        $display("alarm test done");
    endtask
    task automatic t_bytes();
        acc(1'b1, 6'h18, 8'h01);
        acc(1'b1, 6'h19, 8'hFF);
        chk(countdown_value, 16'hFF01);
        rd(6'h19, 8'hFF);
        acc(1'b1, 6'h28, 8'hA5);
        acc(1'b1, 6'h29, 8'h5A);
        rd(6'h28, 8'hA5);
        rd(6'h29, 8'h5A);
        $display("byte test done");
    endtask
    task automatic t_temp();
        repeat (40) @(posedge clk_sys);
        rd(6'h20, 8'hFA);
        acc(1'b1, 6'h20, 8'h11);
        rd(6'h20, 8'hFA);
        acc(1'b1, 6'h30, 8'hA4);
        chk({8'h00, nv_control}, 16'h00A4);
        repeat (8) @(posedge clk_sys);
        acc(1'b1, 6'h20, 8'h00);
        rd(6'h20, 8'h00);
        repeat (40) @(posedge clk_sys);
        #1;
        chk({8'h00, temperature_code}, 16'h0000);
        $display("temperature test done");
    endtask
    task automatic start_gap(output int n);
        n = 0;
        while (sensor_start !== 1'b1) begin
            @(posedge clk_sys);
            #1;
        end
        do begin
            @(posedge clk_sys);
            #1;
            n++;
        end while (sensor_start !== 1'b1);
    endtask
    task automatic t_scan();
        int g1;
        int g2;
        acc(1'b1, 6'h30, 8'h02);
        start_gap(g1);
        acc(1'b1, 6'h30, 8'h03);
        start_gap(g2);
        chk(16'(g2 - g1), 16'h0014);
        chk({8'h00, temperature_code}, 16'h00FA);
        $display("scan test done");
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk_sys);
        #1;
        rst_b = 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        t_reset();
        t_alarm();
        t_bytes();
        t_temp();
        t_scan();
        final_report();
    end
    initial begin
        #20000;
        n_mismatch++;
        final_report();
    end
endmodule
